// File: common/psm_pkg.sv
// constants and types for the port 8..14 pin function selection block
package psm_pkg;
	localparam int PSM_P8_W   = 4;
	localparam int PSM_P9_W   = 4;
	localparam int PSM_P10_W  = 4;
	localparam int PSM_P11_W  = 4;
	localparam int PSM_P12_W  = 5;
	localparam int PSM_P13_W  = 4;
	localparam int PSM_P14_W  = 4;
	localparam int PSM_SYNC_W = 3;
	// function select bit per port group in the all-port function register
	localparam int PSM_FS_P8  = 0;
	localparam int PSM_FS_P9  = 1;
	localparam int PSM_FS_P10 = 2;
	localparam int PSM_FS_P11 = 3;
	localparam int PSM_FS_P13 = 4;
	localparam int PSM_FS_P14 = 5;
	localparam int PSM_FS_W   = 6;
	// port-11 serial pin positions
	localparam int PSM_P11_TX = 2;
	localparam int PSM_P11_RX = 3;
	// port-12 pin positions
	localparam int PSM_P12_IO  = 0;
	localparam int PSM_P12_X1  = 1;
	localparam int PSM_P12_X2  = 2;
	localparam int PSM_P12_XT1 = 3;
	localparam int PSM_P12_XT2 = 4;
	// edge select encoding for the external interrupt input
	typedef enum logic [1:0] {
		PSM_EDGE_NONE = 2'h0,
		PSM_EDGE_RISE = 2'h1,
		PSM_EDGE_FALL = 2'h2,
		PSM_EDGE_BOTH = 2'h3
	} psm_edge_t;
	localparam logic PSM_DIR_OUT = 1'h0;
endpackage

// File: rtl/psm_pin_cell.sv
// one general port pin with control-function override and input synchroniser
`timescale 1ns/10ps
module psm_pin_cell import psm_pkg::*; #(
	parameter int SYNC_W = PSM_SYNC_W
) (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst_b,
	// configuration
	input  wire logic ctl_sel,
	input  wire logic dir_in,
	input  wire logic pu_en,
	input  wire logic out_latch,
	// control function drive
	input  wire logic fn_out,
	input  wire logic fn_oe,
	// pad
	input  wire logic pad_in,
	output logic      pad_out,
	output logic      pad_oe,
	output logic      pad_pu,
	// synchronised pad level
	output logic      pin_level
);
	logic [SYNC_W-1:0] sync_q;
	logic [SYNC_W-1:0] sync_d;
	logic              level_q;
	logic              level_d;

	always_comb begin
		pad_out = ctl_sel ? fn_out : out_latch;          // R14
		pad_oe  = ctl_sel ? fn_oe : (dir_in == PSM_DIR_OUT); // R2 R14
		pad_pu  = ~ctl_sel & (dir_in != PSM_DIR_OUT) & pu_en; // R3
	end

	// a change counts only once the last two stages agree; stage 0 feeds stage 1 alone
	always_comb begin
		sync_d  = {sync_q[SYNC_W-2:0], pad_in};
		level_d = (sync_q[SYNC_W-1] == sync_q[SYNC_W-2]) ? sync_q[SYNC_W-1] : level_q;
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sync_q  <= '0;
			level_q <= 1'h0;
		end else begin
			sync_q  <= sync_d;
			level_q <= level_d;
		end
	end

	assign pin_level = level_q;
endmodule // psm_pin_cell

// File: rtl/psm_port_mux.sv
// pin function selection for general ports 8 through 14
// Operation
// [R1] each pin chooses port or control function on its own; here one select bit switches a whole port, except the port-11 tx pin
// [R2] port mode pin direction follows its own direction bit; the port-11 rx pin is held input whenever port 11 is not segment
// [R3] port mode pull-up follows its pull-up option bit; here it applies only to input pins, and output pins never get the pull-up
// [R4] ports 8-11, 13, 14 pick port or segment via all-port function register
// [R5] port 11 non-segment side covers port use and serial pins
// [R6] serial receive from one port-11 pin, transmit on the adjacent pin
// [R7] port 12: only first pin bidirectional, other four input only
// [R8] external interrupt edge selectable: rising, falling or both
// [R9] main resonator pins or external clock on second; two sub resonator pins
// [R10] with on-chip debug, main resonator pins become debug mode inputs
// [R11] port-12 first pin also carries low-voltage sense input
// [R12] port-14 segment pins may drive key-source scan with segment output
// [R13] key-source output only when lcd mode control enables it
// [R14] control function owns pad drive; port latch and direction ignored
`timescale 1ns/10ps
module psm_port_mux import psm_pkg::*; #(
	parameter int P8_W  = PSM_P8_W,
	parameter int P9_W  = PSM_P9_W,
	parameter int P10_W = PSM_P10_W,
	parameter int P11_W = PSM_P11_W,
	parameter int P12_W = PSM_P12_W,
	parameter int P13_W = PSM_P13_W,
	parameter int P14_W = PSM_P14_W
) (
	// clock and reset
	input  wire logic               clk,
	input  wire logic               rst_b,
	// function selection
	input  wire logic [PSM_FS_W-1:0] all_port_function_select,
	input  wire logic               lcd_mode_control,
	input  wire logic               debug_mode_en,
	input  wire logic               main_clock_ext_sel,
	input  wire psm_edge_t          ext_int_edge_sel,
	// direction registers, 1 = input
	input  wire logic [P8_W-1:0]    port8_direction,
	input  wire logic [P9_W-1:0]    port9_direction,
	input  wire logic [P10_W-1:0]   port10_direction,
	input  wire logic [P11_W-1:0]   port11_direction,
	input  wire logic               port12_direction,
	input  wire logic [P13_W-1:0]   port13_direction,
	input  wire logic [P14_W-1:0]   port14_direction,
	// pull-up option registers
	input  wire logic [P8_W-1:0]    port8_pullup_enable,
	input  wire logic [P9_W-1:0]    port9_pullup_enable,
	input  wire logic [P10_W-1:0]   port10_pullup_enable,
	input  wire logic [P11_W-1:0]   port11_pullup_enable,
	input  wire logic               port12_pullup_enable,
	input  wire logic [P13_W-1:0]   port13_pullup_enable,
	input  wire logic [P14_W-1:0]   port14_pullup_enable,
	// port output latches
	input  wire logic [P8_W-1:0]    port8_latch,
	input  wire logic [P9_W-1:0]    port9_latch,
	input  wire logic [P10_W-1:0]   port10_latch,
	input  wire logic [P11_W-1:0]   port11_latch,
	input  wire logic               port12_latch,
	input  wire logic [P13_W-1:0]   port13_latch,
	input  wire logic [P14_W-1:0]   port14_latch,
	// lcd driver signals
	input  wire logic [P8_W-1:0]    seg8_drive,
	input  wire logic [P9_W-1:0]    seg9_drive,
	input  wire logic [P10_W-1:0]   seg10_drive,
	input  wire logic [P11_W-1:0]   seg11_drive,
	input  wire logic [P13_W-1:0]   seg13_drive,
	input  wire logic [P14_W-1:0]   seg14_drive,
	input  wire logic [P14_W-1:0]   key_source_scan_out,
	output logic [P14_W-1:0]        key_source_active,
	// serial unit
	input  wire logic               serial_transmit_out,
	input  wire logic               serial_tx_enable,
	output logic                    serial_receive_in,
	// interrupt and low-voltage sense
	output logic                    ext_interrupt_in,
	output logic                    ext_low_voltage_sense,
	// oscillator and debug
	output logic                    main_osc_enable,
	output logic                    sub_osc_enable,
	output logic                    main_clock_ext_in,
	output logic                    debug_mode_pin_a,
	output logic                    debug_mode_pin_b,
	// port read values
	output logic [P8_W-1:0]         port8_read,
	output logic [P9_W-1:0]         port9_read,
	output logic [P10_W-1:0]        port10_read,
	output logic [P11_W-1:0]        port11_read,
	output logic [P12_W-1:0]        port12_read,
	output logic [P13_W-1:0]        port13_read,
	output logic [P14_W-1:0]        port14_read,
	// pads
	input  wire logic [P8_W-1:0]    p8_in,
	output logic [P8_W-1:0]         p8_out,
	output logic [P8_W-1:0]         p8_oe,
	output logic [P8_W-1:0]         p8_pu,
	input  wire logic [P9_W-1:0]    p9_in,
	output logic [P9_W-1:0]         p9_out,
	output logic [P9_W-1:0]         p9_oe,
	output logic [P9_W-1:0]         p9_pu,
	input  wire logic [P10_W-1:0]   p10_in,
	output logic [P10_W-1:0]        p10_out,
	output logic [P10_W-1:0]        p10_oe,
	output logic [P10_W-1:0]        p10_pu,
	input  wire logic [P11_W-1:0]   p11_in,
	output logic [P11_W-1:0]        p11_out,
	output logic [P11_W-1:0]        p11_oe,
	output logic [P11_W-1:0]        p11_pu,
	input  wire logic [P12_W-1:0]   p12_in,
	output logic                    p12_out,
	output logic                    p12_oe,
	output logic                    p12_pu,
	input  wire logic [P13_W-1:0]   p13_in,
	output logic [P13_W-1:0]        p13_out,
	output logic [P13_W-1:0]        p13_oe,
	output logic [P13_W-1:0]        p13_pu,
	input  wire logic [P14_W-1:0]   p14_in,
	output logic [P14_W-1:0]        p14_out,
	output logic [P14_W-1:0]        p14_oe,
	output logic [P14_W-1:0]        p14_pu
);
	localparam int NPIN = P8_W + P9_W + P10_W + P11_W + 1 + P13_W + P14_W;

	logic [NPIN-1:0] ctl_v;
	logic [NPIN-1:0] dir_v;
	logic [NPIN-1:0] pu_v;
	logic [NPIN-1:0] lat_v;
	logic [NPIN-1:0] fo_v;
	logic [NPIN-1:0] foe_v;
	logic [NPIN-1:0] in_v;
	logic [NPIN-1:0] out_v;
	logic [NPIN-1:0] oe_v;
	logic [NPIN-1:0] pud_v;
	logic [NPIN-1:0] lvl_v;
	logic [P11_W-1:0] p11_fo;
	logic [P11_W-1:0] p11_ctl;
	logic [P11_W-1:0] p11_dir;
	logic [P12_W-2:0] x_sync_q [PSM_SYNC_W];
	logic [P12_W-2:0] x_lvl_q;
	logic [P12_W-2:0] x_lvl_d;
	logic             int_q;
	logic             int_d;
	logic             p12_lvl;
	logic             seg14_en;

	// serial tx only owns its pin when the unit enables it; other pins stay plain port
	// pins, rx forced to input so its pull-up option can hold an idle line high
	always_comb begin
		p11_ctl = {P11_W{1'h1}};
		p11_fo  = seg11_drive;
		p11_dir = port11_direction;
		if (!all_port_function_select[PSM_FS_P11]) begin
			p11_ctl             = '0; // R5
			p11_ctl[PSM_P11_TX] = serial_tx_enable; // R5 R6
			p11_fo[PSM_P11_TX]  = serial_transmit_out; // R6
			p11_dir[PSM_P11_RX] = ~PSM_DIR_OUT; // R6
		end
	end

	assign seg14_en = all_port_function_select[PSM_FS_P14];
	assign key_source_active = {P14_W{seg14_en & lcd_mode_control}}; // R12 R13

	// pin vectors are packed low to high: p8, p9, p10, p11, p12 io, p13, p14
	always_comb begin
		ctl_v = {{P14_W{seg14_en}},
			{P13_W{all_port_function_select[PSM_FS_P13]}},
			1'h0,
			p11_ctl,
			{P10_W{all_port_function_select[PSM_FS_P10]}},
			{P9_W{all_port_function_select[PSM_FS_P9]}},
			{P8_W{all_port_function_select[PSM_FS_P8]}}}; // R1 R4 R5
		dir_v = {port14_direction, port13_direction, port12_direction, p11_dir,
			port10_direction, port9_direction, port8_direction};
		pu_v  = {port14_pullup_enable, port13_pullup_enable, port12_pullup_enable,
			port11_pullup_enable, port10_pullup_enable, port9_pullup_enable,
			port8_pullup_enable};
		lat_v = {port14_latch, port13_latch, port12_latch, port11_latch,
			port10_latch, port9_latch, port8_latch};
		fo_v  = {(lcd_mode_control ? (seg14_drive ^ key_source_scan_out) : seg14_drive),
			seg13_drive, 1'h0, p11_fo, seg10_drive, seg9_drive, seg8_drive}; // R12 R13
		foe_v = {{P14_W{1'h1}}, {P13_W{1'h1}}, 1'h0, {P11_W{1'h1}},
			{P10_W{1'h1}}, {P9_W{1'h1}}, {P8_W{1'h1}}};
		in_v  = {p14_in, p13_in, p12_in[PSM_P12_IO], p11_in, p10_in, p9_in, p8_in};
	end

	genvar g;
	generate
		for (g = 0; g < NPIN; g++) begin : g_pin
			psm_pin_cell u_cell (
				.clk       (clk),
				.rst_b     (rst_b),
				.ctl_sel   (ctl_v[g]),
				.dir_in    (dir_v[g]),
				.pu_en     (pu_v[g]),
				.out_latch (lat_v[g]),
				.fn_out    (fo_v[g]),
				.fn_oe     (foe_v[g]),
				.pad_in    (in_v[g]),
				.pad_out   (out_v[g]),
				.pad_oe    (oe_v[g]),
				.pad_pu    (pud_v[g]),
				.pin_level (lvl_v[g])
			); // R1 R2 R3 R14
		end
	endgenerate

	always_comb begin
		{p14_out, p13_out, p12_out, p11_out, p10_out, p9_out, p8_out} = out_v;
		{p14_oe, p13_oe, p12_oe, p11_oe, p10_oe, p9_oe, p8_oe} = oe_v;
		{p14_pu, p13_pu, p12_pu, p11_pu, p10_pu, p9_pu, p8_pu} = pud_v;
		{port14_read, port13_read, p12_lvl, port11_read, port10_read, port9_read,
			port8_read} = lvl_v;
	end

	// input-only port-12 pins: three-stage sync, second and third must agree
	always_comb begin
		x_lvl_d = x_lvl_q;
		for (int i = 0; i < P12_W - 1; i++) begin
			if (x_sync_q[PSM_SYNC_W-1][i] == x_sync_q[PSM_SYNC_W-2][i]) begin
				x_lvl_d[i] = x_sync_q[PSM_SYNC_W-1][i];
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			for (int s = 0; s < PSM_SYNC_W; s++) begin
				x_sync_q[s] <= '0;
			end
			x_lvl_q <= '0;
		end else begin
			x_sync_q[0] <= p12_in[P12_W-1:1];
			for (int s = 1; s < PSM_SYNC_W; s++) begin
				x_sync_q[s] <= x_sync_q[s-1];
			end
			x_lvl_q <= x_lvl_d;
		end
	end

	assign port12_read = {x_lvl_q, p12_lvl}; // R7

	// edge detect works on the agreed level, so glitches narrower than a clock are dropped
	always_comb begin
		int_d = p12_lvl;
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			int_q <= 1'h0;
		end else begin
			int_q <= int_d;
		end
	end

	always_comb begin
		unique case (ext_int_edge_sel)
			PSM_EDGE_NONE: ext_interrupt_in = 1'h0;
			PSM_EDGE_RISE: ext_interrupt_in = p12_lvl & ~int_q; // R8
			PSM_EDGE_FALL: ext_interrupt_in = ~p12_lvl & int_q; // R8
			PSM_EDGE_BOTH: ext_interrupt_in = p12_lvl ^ int_q; // R8
		endcase
	end

	assign ext_low_voltage_sense = p12_lvl; // R11

	// resonator pins are analog in the pad; here only the enables and the clock path
	always_comb begin
		main_osc_enable   = ~debug_mode_en & ~main_clock_ext_sel; // R9 R10
		main_clock_ext_in = (~debug_mode_en & main_clock_ext_sel) ?
			p12_in[PSM_P12_X2] : 1'h0; // R9
		sub_osc_enable    = 1'h1; // R9
		debug_mode_pin_a  = debug_mode_en & x_lvl_q[PSM_P12_X1-1]; // R10
		debug_mode_pin_b  = debug_mode_en & x_lvl_q[PSM_P12_X2-1]; // R10
		serial_receive_in = ~all_port_function_select[PSM_FS_P11] &
			port11_read[PSM_P11_RX]; // R6
	end
endmodule // psm_port_mux

// File: dv/psm_port_mux_sva.sv
// assertions on the port 8..14 pin function selection block
`timescale 1ns/10ps
module psm_port_mux_chk import psm_pkg::*; (
	// clock and reset
	input wire logic       clk,
	input wire logic       rst_b,
	// selection
	input wire logic [5:0] all_port_function_select,
	input wire logic       lcd_mode_control,
	input wire psm_edge_t  ext_int_edge_sel,
	input wire logic [3:0] port8_direction,
	input wire logic [3:0] port8_pullup_enable,
	input wire logic       port12_direction,
	// functions
	input wire logic [3:0] seg8_drive,
	input wire logic       serial_transmit_out,
	input wire logic       serial_tx_enable,
	input wire logic       serial_receive_in,
	input wire logic [3:0] key_source_active,
	input wire logic       ext_interrupt_in,
	input wire logic       ext_low_voltage_sense,
	// pads
	input wire logic [3:0] p8_out,
	input wire logic [3:0] p8_oe,
	input wire logic [3:0] p8_pu,
	input wire logic [3:0] p11_out,
	input wire logic [3:0] p11_oe,
	input wire logic       p12_oe
);
	logic [5:0] fs;
	assign fs = all_port_function_select;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	AST_DIR: assert property (!fs[PSM_FS_P8] |-> p8_oe == ~port8_direction)
		else $error("port drive enable wrong");
	// pull-up is only judged on input pins; output pins may drop it
	AST_PU: assert property (!fs[PSM_FS_P8] |->
		(p8_pu & port8_direction) == (port8_pullup_enable & port8_direction))
		else $error("pull-up wrong");
	AST_SEG: assert property (fs[PSM_FS_P8] |-> p8_oe == 4'hf && p8_out == seg8_drive)
		else $error("segment drive wrong");
	AST_KEY: assert property (key_source_active == {4{fs[PSM_FS_P14] & lcd_mode_control}})
		else $error("key source enable wrong");
	AST_TX: assert property (!fs[PSM_FS_P11] && serial_tx_enable |->
		p11_oe[PSM_P11_TX] && p11_out[PSM_P11_TX] == serial_transmit_out)
		else $error("transmit pin wrong");
	AST_RX: assert property (fs[PSM_FS_P11] ? !serial_receive_in : !p11_oe[PSM_P11_RX])
		else $error("receive pin wrong");
	AST_P12: assert property (p12_oe == !port12_direction)
		else $error("port 12 drive wrong");
	AST_INT: assert property ($stable(ext_int_edge_sel) |-> ext_interrupt_in ==
		($rose(ext_low_voltage_sense) && ext_int_edge_sel[0] ||
		$fell(ext_low_voltage_sense) && ext_int_edge_sel[1])) else $error("edge pulse wrong");
endmodule // psm_port_mux_chk
bind psm_port_mux psm_port_mux_chk i_psm_port_mux_chk (.*);

// File: dv/psm_pad_model.sv
// pad-side model: external drivers, pull-ups and released lines
`timescale 1ns/10ps
module psm_pad_model #(
	parameter int W = 4
) (
	// clock
	input wire logic         clk,
	// design side
	input wire logic [W-1:0] pad_out,
	input wire logic [W-1:0] pad_oe,
	input wire logic [W-1:0] pad_pu,
	// external driver
	input wire logic [W-1:0] ext_en,
	input wire logic [W-1:0] ext_val,
	output logic [W-1:0]     pad_in
);
	logic [W-1:0] last_q = '0;
	// a floating line flips every cycle so a stale level never passes
	always @(posedge clk) last_q <= pad_in;
	assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val) |
		(~pad_oe & ~ext_en & (pad_pu | ~last_q));
endmodule // psm_pad_model

// File: dv/psm_port_mux_test.sv
// self-checking bench for the port 8..14 pin function selection block
`timescale 1ns/10ps
module psm_port_mux_test import psm_pkg::*; ;
	logic       clk = 1'b0, rst_b = 1'b0, lcd_mode_control = 1'b0, debug_mode_en = 1'b0;
	logic       main_clock_ext_sel = 1'b1, serial_transmit_out = 1'b0, serial_tx_enable = 1'b0;
	logic       port12_direction = 1'b1, port12_pullup_enable = 1'b0, port12_latch = 1'b0;
	logic [5:0] all_port_function_select = 6'h00;
	psm_edge_t  ext_int_edge_sel = PSM_EDGE_NONE;
	logic [3:0] port8_direction = 4'hf, port9_direction = 4'hf, port10_direction = 4'hf;
	logic [3:0] port11_direction = 4'hf, port13_direction = 4'hf, port14_direction = 4'hf;
	logic [3:0] port8_pullup_enable = 4'h0, port9_pullup_enable = 4'h0;
	logic [3:0] port10_pullup_enable = 4'h0, port11_pullup_enable = 4'h0;
	logic [3:0] port13_pullup_enable = 4'h0, port14_pullup_enable = 4'h0;
	logic [3:0] port8_latch = 4'h0, port9_latch = 4'h0, port10_latch = 4'h0;
	logic [3:0] port11_latch = 4'h0, port13_latch = 4'h0, port14_latch = 4'h0;
	logic [3:0] seg8_drive = 4'h1, seg9_drive = 4'h2, seg10_drive = 4'h3, seg11_drive = 4'h4;
	logic [3:0] seg13_drive = 4'h5, seg14_drive = 4'h6, key_source_scan_out = 4'h5;
	logic [3:0] p9_in = 4'h0, p10_in = 4'h0, p13_in = 4'h0, p14_in = 4'h0;
	logic [3:0] x8_en = 4'h0, x8_val = 4'h0, x11_en = 4'h0, x11_val = 4'h0, p8_in, p11_in;
	logic [4:0] x12_en = 5'h00, x12_val = 5'h00, p12_in, port12_read;
	logic [3:0] key_source_active, port8_read, port9_read, port10_read, port11_read;
	logic [3:0] port13_read, port14_read, p8_out, p8_oe, p8_pu, p9_out, p9_oe, p9_pu;
	logic [3:0] p10_out, p10_oe, p10_pu, p11_out, p11_oe, p11_pu, p13_out, p13_oe, p13_pu;
	logic [3:0] p14_out, p14_oe, p14_pu;
	logic       serial_receive_in, ext_interrupt_in, ext_low_voltage_sense, main_osc_enable;
	logic       sub_osc_enable, main_clock_ext_in, debug_mode_pin_a, debug_mode_pin_b;
	logic       p12_out, p12_oe, p12_pu;
	int         err_count = 0, checks_done = 0, cyc = 0, pulses = 0;
	psm_port_mux i_psm_port_mux (.*);
	psm_pad_model #(.W(4)) i_psm_pad_model_p8 (.clk(clk), .pad_out(p8_out), .pad_oe(p8_oe),
		.pad_pu(p8_pu), .ext_en(x8_en), .ext_val(x8_val), .pad_in(p8_in));
	psm_pad_model #(.W(4)) i_psm_pad_model_p11 (.clk(clk), .pad_out(p11_out), .pad_oe(p11_oe),
		.pad_pu(p11_pu), .ext_en(x11_en), .ext_val(x11_val), .pad_in(p11_in));
	psm_pad_model #(.W(5)) i_psm_pad_model_p12 (.clk(clk), .pad_out({4'h0, p12_out}),
		.pad_oe({4'h0, p12_oe}), .pad_pu({4'h0, p12_pu}), .ext_en(x12_en), .ext_val(x12_val),
		.pad_in(p12_in));
	always #2.5 clk = ~clk;
	always @(posedge clk) if (ext_interrupt_in === 1'b1) pulses++;
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	function automatic logic [7:0] grp(input int g);
		case (g)
			0: return {p8_oe, p8_out};
			1: return {p9_oe, p9_out};
			2: return {p10_oe, p10_out};
			3: return {p11_oe, p11_out};
			4: return {p13_oe, p13_out};
			default: return {p14_oe, p14_out};
		endcase
	endfunction
	// the run should take about 135 cycles
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			err_count++;
			report_and_stop();
		end
	end
	initial begin
		repeat (5) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		port8_direction <= 4'ha;
		port8_latch <= 4'h5;
		port8_pullup_enable <= 4'h2;
		x8_en <= 4'h8;
		wt(6);
		cmp(p8_oe, 8'h05);
		cmp(p8_pu & 4'ha, 8'h02);
		cmp(port8_read, 8'h07);
		$display("test port mode done");
		for (int g = 0; g < 6; g++) begin
			@(posedge clk);
			all_port_function_select <= 6'h01 << g;
			wt(1);
			cmp(grp(g), 8'(8'hf1 + g));
			if (g != 0) cmp(p8_oe, 8'h05);
		end
		cmp(key_source_active, 8'h00);
		@(posedge clk);
		lcd_mode_control <= 1'b1;
		wt(1);
		cmp({key_source_active, p14_out}, 8'hf3);
		$display("test segment done");
		@(posedge clk);
		all_port_function_select <= 6'h00;
		serial_tx_enable <= 1'b1;
		port11_direction <= 4'h0;
		port11_latch <= 4'hf;
		port11_pullup_enable <= 4'h8;
		x11_en <= 4'h8;
		x11_val <= 4'h8;
		wt(6);
		cmp({p11_oe, p11_out & 4'h7}, 8'h73);
		cmp(serial_receive_in, 8'h01);
		cmp(p11_pu, 8'h08);
		@(posedge clk);
		all_port_function_select <= 6'h08;
		wt(1);
		cmp(serial_receive_in, 8'h00);
		$display("test serial done");
		@(posedge clk);
		x12_en <= 5'h1e;
		x12_val <= 5'h0e;
		port12_direction <= 1'b0;
		port12_latch <= 1'b1;
		wt(6);
		cmp(port12_read, 8'h0f);
		cmp({main_clock_ext_in, sub_osc_enable}, 8'h03);
		@(posedge clk);
		debug_mode_en <= 1'b1;
		wt(1);
		cmp({main_osc_enable, main_clock_ext_in}, 8'h00);
		cmp({debug_mode_pin_a, debug_mode_pin_b}, 8'h03);
		@(posedge clk);
		debug_mode_en <= 1'b0;
		main_clock_ext_sel <= 1'b0;
		wt(1);
		cmp({main_osc_enable, main_clock_ext_in}, 8'h02);
		cmp({debug_mode_pin_a, debug_mode_pin_b}, 8'h00);
		@(posedge clk);
		port12_direction <= 1'b1;
		x12_en <= 5'h1f;
		wt(8);
		for (int s = 0; s < 4; s++) begin
			@(posedge clk);
			ext_int_edge_sel <= psm_edge_t'(s);
			wt(1);
			pulses = 0;
			@(posedge clk);
			x12_val[0] <= 1'b1;
			wt(8);
			cmp(8'(pulses), 8'(s & 1));
			cmp(ext_low_voltage_sense, 8'h01);
			@(posedge clk);
			x12_val[0] <= 1'b0;
			wt(8);
			cmp(8'(pulses), 8'((s & 1) + (s >> 1)));
		end
		$display("test port 12 done");
		report_and_stop();
	end
endmodule // psm_port_mux_test
